/* rtl/vic_top.sv */
`timescale 1ns/100ps
`include "vic_defines.svh"

// What this block does
// - Flags caught at sample phase, polled in the next machine cycle.
// - No call while same or higher level service is in progress.
// - Call waits until polling cycle is the instruction's last cycle.
// - After return or enable/priority write, two more instructions run.
// - Blocked requests are not remembered; each poll starts afresh.
// - High request sampled in C3 is vectored in C5 and C6.
// - Call pushes PC without status word, then loads the vector.
// - Vectors: mode 0003, t0 000b, ext1 0013, t1 001b, ddc 002b.
// - Return from interrupt clears current level's in-progress marker.
// - Plain subroutine exit leaves the in-progress marker set.
// - Global gate bit 7 clear blocks all acknowledgement.
// - Enable bits 5,3,2,1,0 gate sources; bits 6 and 4 reserved.
// - Priority bits 5,3,2,1,0 select high level when set.
// - Same level ties: mode change, ddc, timer0, ext1, timer1.
// - Low routine preempted only by high; high routine never.
// - Timer and edge flags cleared at call; ddc flag left for software.
module vic_top
  import vic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] req_flags,
  input wire logic ext1_edge_mode,
  input wire logic modechg_edge_mode,
  input wire vic_core_stat_t core_stat,
  input wire logic call_done,
  output vic_call_t call_out,
  output logic [4:0] flag_clear,
  output logic [1:0] in_service,
  output logic irq_out
);

  // ==========================================
  // Machine cycle timing
  logic sample_strobe;
  logic cycle_end;

  vic_phase_timer #(
    .PHASES(`VIC_PHASES)
  ) u_phase (
    .pclk(pclk),
    .presetn(presetn),
    .sample_strobe(sample_strobe),
    .cycle_end(cycle_end)
  );

  // ==========================================
  // APB registers
  logic [7:0] irq_enable_mask_reg;
  logic [7:0] irq_priority_select_reg;
  logic [4:0] evt_status_reg;
  logic [4:0] evt_mask_reg;
  logic apb_access;
  logic apb_wr;
  logic addr_ok;

  localparam logic [11:0] STAT_OFFSET = 12'h0c0;
  localparam logic [11:0] MASK_OFFSET = 12'h0c4;

  assign apb_access = psel && penable && !pready;
  assign apb_wr = apb_access && pwrite;
  assign addr_ok = (paddr == `VIC_ENABLE_OFFSET) ||
    (paddr == `VIC_PRIO_OFFSET) || (paddr == STAT_OFFSET) ||
    (paddr == MASK_OFFSET);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !addr_ok;
      prdata <= 32'h0;
      if (apb_access && !pwrite) begin
        unique case (paddr)
          `VIC_ENABLE_OFFSET: prdata <= {24'h0, irq_enable_mask_reg};
          `VIC_PRIO_OFFSET: prdata <= {24'h0, irq_priority_select_reg};
          STAT_OFFSET: prdata <= {27'h0, evt_status_reg};
          MASK_OFFSET: prdata <= {27'h0, evt_mask_reg};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_mask_reg <= `VIC_ENABLE_RESET;
      irq_priority_select_reg <= `VIC_PRIO_RESET;
    end else if (apb_wr && paddr == `VIC_ENABLE_OFFSET) begin
      irq_enable_mask_reg <= pwdata[7:0] & `VIC_ENABLE_MASK;
    end else if (apb_wr && paddr == `VIC_PRIO_OFFSET) begin
      irq_priority_select_reg <= pwdata[7:0] & `VIC_IMPL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_reg <= 5'h0;
    end else if (apb_wr && paddr == MASK_OFFSET) begin
      evt_mask_reg <= pwdata[4:0];
    end
  end

  // ==========================================
  // Register bit to source order mapping
  logic [4:0] src_enable;
  logic [4:0] src_high;

  always_comb begin
    src_enable[SRC_MC] = irq_enable_mask_reg[`VIC_MC_BIT];
    src_enable[SRC_DDC] = irq_enable_mask_reg[`VIC_DDC_BIT];
    src_enable[SRC_T0] = irq_enable_mask_reg[`VIC_T0_BIT];
    src_enable[SRC_X1] = irq_enable_mask_reg[`VIC_X1_BIT];
    src_enable[SRC_T1] = irq_enable_mask_reg[`VIC_T1_BIT];
    src_high[SRC_MC] = irq_priority_select_reg[`VIC_MC_BIT];
    src_high[SRC_DDC] = irq_priority_select_reg[`VIC_DDC_BIT];
    src_high[SRC_T0] = irq_priority_select_reg[`VIC_T0_BIT];
    src_high[SRC_X1] = irq_priority_select_reg[`VIC_X1_BIT];
    src_high[SRC_T1] = irq_priority_select_reg[`VIC_T1_BIT];
  end

  // ==========================================
  // Sampling and polling
  logic [4:0] sampled_reg;
  logic [4:0] poll_reg;
  logic defer_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_reg <= 5'h0;
    end else if (sample_strobe) begin
      sampled_reg <= req_flags;
    end
  end

  // Samples held for the whole following machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_reg <= 5'h0;
    end else if (cycle_end) begin
      poll_reg <= sampled_reg;
    end
  end

  // Two instructions must finish after return or enable/priority write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      defer_reg <= 1'b0;
    end else if (cycle_end && core_stat.last_cycle) begin
      defer_reg <= core_stat.is_irq_return_instr || core_stat.ie_ip_write;
    end
  end

  logic [4:0] cand;
  logic [4:0] cand_hi;
  logic [4:0] cand_lo;
  logic hi_found;
  logic lo_found;
  logic [2:0] hi_idx;
  logic [2:0] lo_idx;

  assign cand = poll_reg & src_enable &
    {5{irq_enable_mask_reg[`VIC_GATE_BIT]}};
  assign cand_hi = cand & src_high;
  assign cand_lo = cand & ~src_high;

  vic_arbiter #(
    .N(5)
  ) u_arb_hi (
    .req(cand_hi),
    .found(hi_found),
    .idx(hi_idx)
  );

  vic_arbiter #(
    .N(5)
  ) u_arb_lo (
    .req(cand_lo),
    .found(lo_found),
    .idx(lo_idx)
  );

  logic allow_hi;
  logic allow_lo;
  logic blocked;
  logic take;
  logic take_high;
  logic [2:0] take_idx;

  // Low service blocks low; high service blocks everything
  assign allow_hi = !in_service[1];
  assign allow_lo = !in_service[1] && !in_service[0];
  assign blocked = !cycle_end || !core_stat.last_cycle ||
    core_stat.is_irq_return_instr || core_stat.ie_ip_write || defer_reg ||
    call_out.valid;
  assign take_high = hi_found && allow_hi;
  assign take = !blocked && (take_high || (lo_found && allow_lo));
  assign take_idx = take_high ? hi_idx : lo_idx;

  function automatic logic [15:0] vec_of(input logic [2:0] s);
    logic [15:0] v;
    v = `VIC_VEC_MC;
    unique case (s)
      3'(SRC_MC): v = `VIC_VEC_MC;
      3'(SRC_DDC): v = `VIC_VEC_DDC;
      3'(SRC_T0): v = `VIC_VEC_T0;
      3'(SRC_X1): v = `VIC_VEC_X1;
      3'(SRC_T1): v = `VIC_VEC_T1;
      default: v = `VIC_VEC_MC;
    endcase
    return v;
  endfunction

  // ==========================================
  // Call request to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_out <= '0;
    end else if (take) begin
      call_out.valid <= 1'b1;
      call_out.src <= take_idx;
      call_out.high <= take_high;
      call_out.vector <= vec_of(take_idx);
    end else if (call_done) begin
      call_out.valid <= 1'b0;
    end
  end

  // Hardware flag clear pulse when the call executes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_clear <= 5'h0;
    end else begin
      flag_clear <= 5'h0;
      if (call_out.valid && call_done) begin
        unique case (call_out.src)
          3'(SRC_T0): flag_clear[SRC_T0] <= 1'b1;
          3'(SRC_T1): flag_clear[SRC_T1] <= 1'b1;
          3'(SRC_X1): flag_clear[SRC_X1] <= ext1_edge_mode;
          3'(SRC_MC): flag_clear[SRC_MC] <= modechg_edge_mode;
          default: flag_clear <= 5'h0;
        endcase
      end
    end
  end

  // ==========================================
  // In-progress markers: bit1 high level, bit0 low level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_service <= 2'b00;
    end else if (call_out.valid && call_done) begin
      in_service[call_out.high] <= 1'b1;
    end else if (cycle_end && core_stat.last_cycle && core_stat.is_irq_return_instr) begin
      if (in_service[1]) begin
        in_service[1] <= 1'b0;
      end else begin
        in_service[0] <= 1'b0;
      end
    end
    // A plain return leaves the markers untouched
  end

  // ==========================================
  // Event status and interrupt output
  logic [4:0] evt_set;

  assign evt_set = (call_out.valid && call_done) ?
    5'(5'h1 << call_out.src) : 5'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_reg <= 5'h0;
    end else begin
      if (apb_wr && paddr == STAT_OFFSET) begin
        evt_status_reg <= (evt_status_reg & ~pwdata[4:0]) | evt_set;
      end else begin
        evt_status_reg <= evt_status_reg | evt_set;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_status_reg & evt_mask_reg);
    end
  end

  // ==========================================
  // Checks
  chk_high_blocks_all: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(call_out.valid) |-> !$past(in_service[1]))
    else $error("call taken during high service");

  chk_gate_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(call_out.valid) |-> $past(irq_enable_mask_reg[`VIC_GATE_BIT]))
    else $error("call taken with gate off");

  chk_last_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(call_out.valid) |-> $past(cycle_end && core_stat.last_cycle))
    else $error("call outside last cycle");

  chk_defer_irq_return_instr: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(call_out.valid) |->
    !$past(core_stat.is_irq_return_instr || core_stat.ie_ip_write || defer_reg))
    else $error("call inside deferral");

  chk_vector_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(call_out.valid) && call_out.src == 3'(SRC_DDC) |->
    call_out.vector == `VIC_VEC_DDC)
    else $error("wrong ddc vector");

  chk_low_blocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(call_out.valid) && $past(in_service[0]) |-> call_out.high)
    else $error("low call during low service");

  chk_irq_return_instr_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    cycle_end && core_stat.last_cycle && core_stat.is_irq_return_instr &&
    !(call_out.valid && call_done) && in_service == 2'b01 |=>
    in_service == 2'b00)
    else $error("return did not clear marker");

  chk_ret_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_stat.is_ret && !core_stat.is_irq_return_instr && in_service[0] |=>
    in_service[0])
    else $error("plain return cleared marker");

  chk_ddc_not_cleared: assert property (
    @(posedge pclk) disable iff (!presetn)
    !flag_clear[SRC_DDC])
    else $error("ddc flag cleared by hardware");

  chk_sample_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    cycle_end |=> poll_reg == $past(sampled_reg))
    else $error("poll copy wrong");

endmodule

/* rtl/vic_defines.svh */
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// APB byte addresses of the two registers
`define VIC_ENABLE_OFFSET 12'ha8
`define VIC_PRIO_OFFSET 12'hb8

// Enable register fields
`define VIC_GATE_BIT 7
`define VIC_DDC_BIT 5
`define VIC_T1_BIT 3
`define VIC_X1_BIT 2
`define VIC_T0_BIT 1
`define VIC_MC_BIT 0
`define VIC_IMPL_MASK 8'h2f
`define VIC_ENABLE_MASK 8'haf
`define VIC_ENABLE_RESET 8'h00
`define VIC_PRIO_RESET 8'h00

// Vector addresses
`define VIC_VEC_MC 16'h0003
`define VIC_VEC_T0 16'h000b
`define VIC_VEC_X1 16'h0013
`define VIC_VEC_T1 16'h001b
`define VIC_VEC_DDC 16'h002b

// Machine cycle timing: sample phase index within a machine cycle
`define VIC_PHASES 12
`define VIC_SAMPLE_PHASE 4'h9

`endif

/* rtl/vic_pkg.sv */
package vic_pkg;

  // Source order on the request vector: bit n is source n
  typedef enum logic [2:0] {
    SRC_MC,
    SRC_DDC,
    SRC_T0,
    SRC_X1,
    SRC_T1
  } vic_src_t;

  typedef struct packed {
    logic last_cycle;
    logic is_irq_return_instr;
    logic is_ret;
    logic ie_ip_write;
  } vic_core_stat_t;

  typedef struct packed {
    logic valid;
    logic [2:0] src;
    logic high;
    logic [15:0] vector;
  } vic_call_t;

endpackage

/* rtl/vic_phase_timer.sv */
`timescale 1ns/100ps
`include "vic_defines.svh"

// ==========================================
// Machine cycle phase counter
module vic_phase_timer
  import vic_pkg::*;
#(
  parameter int PHASES = `VIC_PHASES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic sample_strobe,
  output logic cycle_end
);

  if (PHASES < 10 || PHASES > 16) begin : g_bad_phases
    $error("vic_phase_timer: PHASES out of range");
  end

  logic [3:0] phase_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 4'h0;
    end else if (phase_reg == 4'(PHASES - 1)) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  assign sample_strobe = (phase_reg == `VIC_SAMPLE_PHASE);
  assign cycle_end = (phase_reg == 4'(PHASES - 1));

endmodule

/* rtl/vic_arbiter.sv */
`timescale 1ns/100ps
`include "vic_defines.svh"

// ==========================================
// Fixed-order pick among sources of one level
module vic_arbiter
  import vic_pkg::*;
#(
  parameter int N = 5
) (
  input wire logic [N-1:0] req,
  output logic found,
  output logic [2:0] idx
);

  if (N < 1 || N > 8) begin : g_bad_width
    $error("vic_arbiter: N out of range");
  end

  always_comb begin
    found = 1'b0;
    idx = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = 3'(i);
      end
    end
  end

endmodule

/* sim/vic_core_model.sv */
`timescale 1ns/100ps

// ==========================================
// Core sequencer model: instruction status and call execution
module vic_core_model
  import vic_pkg::*;
#(
  parameter int PHASES = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire vic_core_stat_t instr,
  input wire logic [3:0] delay,
  input wire vic_call_t call_out,
  output vic_core_stat_t core_stat,
  output logic call_done
);
  logic [3:0] phase_reg;
  logic [3:0] wait_reg;

  // One instruction status per machine cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 4'h0;
      core_stat <= '0;
    end else begin
      phase_reg <= (phase_reg == 4'(PHASES - 1)) ? 4'h0 : phase_reg + 4'h1;
      if (phase_reg == 4'h0) begin
        core_stat <= instr;
      end
    end
  end

  // Push PC and load vector after a chosen delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 4'h0;
      call_done <= 1'b0;
    end else begin
      call_done <= 1'b0;
      if (!call_out.valid || call_done) begin
        wait_reg <= 4'h0;
      end else if (wait_reg == delay) begin
        call_done <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

/* sim/vic_top_tb_top.sv */
`timescale 1ns/100ps

// ==========================================
// Testbench top
module vic_top_tb_top
  import vic_pkg::*;
;
  localparam vic_core_stat_t NORM = 4'h8;
  localparam vic_core_stat_t IRQ_RETURN_INSTR = 4'hc;
  localparam vic_core_stat_t RET = 4'ha;
  localparam vic_core_stat_t MID = 4'h0;
  localparam vic_core_stat_t WRIE = 4'h9;
  localparam logic [15:0] vec_tbl [5] = '{16'h0003, 16'h002b, 16'h000b,
                                          16'h0013, 16'h001b};
  logic pclk, presetn, psel, penable, pwrite, err, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, call_done, irq_out;
  logic ext1_edge_mode, modechg_edge_mode;
  logic [4:0] req_flags, flag_clear, clr_mask;
  logic [1:0] in_service;
  logic [3:0] delay;
  vic_core_stat_t core_stat, instr;
  vic_call_t call_out;
  int bad_count, n_tests;

  assign clr_mask = {1'b1, ext1_edge_mode, 1'b1, 1'b0, modechg_edge_mode};

  vic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_flags(req_flags), .ext1_edge_mode(ext1_edge_mode),
    .modechg_edge_mode(modechg_edge_mode), .core_stat(core_stat),
    .call_done(call_done), .call_out(call_out), .flag_clear(flag_clear),
    .in_service(in_service), .irq_out(irq_out));

  vic_core_model #(.PHASES(12)) u_core (.pclk(pclk), .presetn(presetn),
    .instr(instr), .delay(delay), .call_out(call_out),
    .core_stat(core_stat), .call_done(call_done));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    @(posedge pclk);
  endtask

  task automatic run_instr(input vic_core_stat_t k);
    instr <= k;
    repeat (12) @(posedge pclk);
    instr <= NORM;
    repeat (12) @(posedge pclk);
  endtask

  task automatic get_call(input logic want, input logic [2:0] s,
                          input logic h);
    int i;
    logic [4:0] got;
    i = 0;
    got = 5'h00;
    while (call_out.valid !== 1'b1 && i < 60) begin
      @(posedge pclk);
      i++;
    end
    chk(32'(call_out.valid), 32'(want));
    if (want) begin
      chk(32'(call_out.src), 32'(s));
      chk(32'(call_out.high), 32'(h));
      chk(32'(call_out.vector), 32'(vec_tbl[s]));
      req_flags[s] <= 1'b0;
      repeat (12) begin
        @(posedge pclk);
        got = got | flag_clear;
      end
      chk(32'(got), 32'(clr_mask & (5'h01 << s)));
      chk(32'(in_service[h]), 32'h1);
    end
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    req_flags = 5'h00;
    ext1_edge_mode = 1'b1;
    modechg_edge_mode = 1'b0;
    instr = NORM;
    delay = 4'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'ha8, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'hb8, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'ha8, 32'hff);
    apb(1'b0, 12'ha8, 32'h0);
    chk(rd, 32'haf);
    apb(1'b1, 12'hb8, 32'hff);
    apb(1'b0, 12'hb8, 32'h0);
    chk(rd, 32'h2f);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 12'hb8, 32'h0);
    $display("Test registers done");
    for (int s = 0; s < 5; s++) begin
      delay <= 4'(s);
      req_flags[s] <= 1'b1;
      get_call(1'b1, 3'(s), 1'b0);
      run_instr(IRQ_RETURN_INSTR);
      chk(32'(in_service), 32'h0);
    end
    $display("Test vectors done");
    req_flags <= 5'h1f;
    get_call(1'b1, 3'h0, 1'b0);
    get_call(1'b0, 3'h0, 1'b0);
    run_instr(RET);
    chk(32'(in_service), 32'h1);
    apb(1'b1, 12'hb8, 32'h08);
    get_call(1'b1, 3'h4, 1'b1);
    chk(32'(in_service), 32'h3);
    apb(1'b1, 12'hb8, 32'h28);
    get_call(1'b0, 3'h0, 1'b0);
    run_instr(IRQ_RETURN_INSTR);
    repeat (10) @(posedge pclk);
    chk(32'(call_out.valid), 32'h0);
    get_call(1'b1, 3'h1, 1'b1);
    req_flags <= 5'h00;
    run_instr(IRQ_RETURN_INSTR);
    run_instr(IRQ_RETURN_INSTR);
    chk(32'(in_service), 32'h0);
    apb(1'b1, 12'hb8, 32'h0);
    $display("Test priority done");
    instr <= MID;
    req_flags[2] <= 1'b1;
    get_call(1'b0, 3'h0, 1'b0);
    instr <= NORM;
    get_call(1'b1, 3'h2, 1'b0);
    run_instr(IRQ_RETURN_INSTR);
    apb(1'b1, 12'ha8, 32'h2f);
    req_flags[3] <= 1'b1;
    get_call(1'b0, 3'h0, 1'b0);
    req_flags[3] <= 1'b0;
    repeat (24) @(posedge pclk);
    apb(1'b1, 12'ha8, 32'haf);
    get_call(1'b0, 3'h0, 1'b0);
    req_flags[2] <= 1'b1;
    run_instr(WRIE);
    seen = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      seen = seen | call_out.valid;
    end
    chk(32'(seen), 32'h0);
    chk(32'(in_service), 32'h0);
    get_call(1'b1, 3'h2, 1'b0);
    run_instr(IRQ_RETURN_INSTR);
    $display("Test blocking done");
    chk(32'(irq_out), 32'h0);
    apb(1'b1, 12'hc4, 32'h1f);
    repeat (2) @(posedge pclk);
    chk(32'(irq_out), 32'h1);
    apb(1'b1, 12'hc0, 32'h1f);
    repeat (2) @(posedge pclk);
    chk(32'(irq_out), 32'h0);
    apb(1'b0, 12'hc0, 32'h0);
    chk(rd, 32'h0);
    $display("Test events done");
    wrap_up();
  end
endmodule
